// ---- logic/fab_defs.svh ----
// Behaviour
// - A read drives chip select and output enable low, write enable high, reset inactive.
// - A command write drives chip select and write enable low with output enable high.
// - The address is bits 18..0 in word mode and 18..-1 in byte mode.
// - A sector protect write uses write levels, reset at high voltage, A6 low, A1 high, A0 low.
// - A sector unprotect write is the same with A6 high.
`ifndef FAB_DEFS_SVH
`define FAB_DEFS_SVH
`define FAB_CLK_PERIOD_NS 5
`define FAB_T_ACC_NS 120
`define FAB_T_ACC_CYC ((`FAB_T_ACC_NS + `FAB_CLK_PERIOD_NS - 1) / `FAB_CLK_PERIOD_NS)
`define FAB_T_WP_NS 50
`define FAB_T_WP_CYC ((`FAB_T_WP_NS + `FAB_CLK_PERIOD_NS - 1) / `FAB_CLK_PERIOD_NS)
`define FAB_T_SETUP_NS 10
`define FAB_T_SETUP_CYC ((`FAB_T_SETUP_NS + `FAB_CLK_PERIOD_NS - 1) / `FAB_CLK_PERIOD_NS)
`define FAB_T_RP_NS 500
`define FAB_T_RP_CYC ((`FAB_T_RP_NS + `FAB_CLK_PERIOD_NS - 1) / `FAB_CLK_PERIOD_NS)
`define FAB_T_RH_NS 50
`define FAB_T_RH_CYC ((`FAB_T_RH_NS + `FAB_CLK_PERIOD_NS - 1) / `FAB_CLK_PERIOD_NS)
`define FAB_PROT_A6_BIT 6
`define FAB_PROT_A1_BIT 1
`define FAB_PROT_A0_BIT 0
`define FAB_OP_READ 3'h0
`define FAB_OP_WRITE 3'h1
`define FAB_OP_PROTECT 3'h2
`define FAB_OP_UNPROTECT 3'h3
`define FAB_OP_RESET 3'h4
`endif

// ---- logic/fab_pkg.sv ----
package fab_pkg;
    typedef enum logic [2:0] {
        FAB_IDLE = 3'h0,
        FAB_SETUP = 3'h1,
        FAB_STROBE = 3'h3,
        FAB_HOLD = 3'h2,
        FAB_RESET = 3'h6,
        FAB_RECOVER = 3'h7
    } fab_state_t;

    typedef struct packed {
        logic [2:0] op;
        logic word_mode;
        logic [19:0] addr;
        logic [15:0] wdata;
    } fab_req_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic rst_n;
        logic hv_en;
    } fab_ctl_t;
endpackage : fab_pkg

// ---- logic/fab_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fab_defs.svh"
module fab_host (
    // clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // user request
    input wire logic REQ_VALID,
    input wire fab_pkg::fab_req_t REQ,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [15:0] RSP_DATA,
    // flash pins
    output logic [18:0] ADDR,
    output logic CE_N,
    output logic OE_N,
    output logic WE_N,
    output logic RESET_N,
    output logic HIGH_VOLTAGE_LEVEL,
    output logic BYTE_N,
    input wire logic [15:0] DQ_I,
    output logic [15:0] DQ_O,
    output logic [15:0] DQ_OE_N,
    input wire logic READY_BUSY_OUT
);
    localparam logic [7:0] ACC_CYC = 8'(`FAB_T_ACC_CYC);
    localparam logic [7:0] WP_CYC = 8'(`FAB_T_WP_CYC);
    localparam logic [7:0] SU_CYC = 8'(`FAB_T_SETUP_CYC);
    localparam logic [7:0] RP_CYC = 8'(`FAB_T_RP_CYC);
    localparam logic [7:0] RH_CYC = 8'(`FAB_T_RH_CYC);

    fab_pkg::fab_state_t state_reg, state_next;
    fab_pkg::fab_req_t req_reg, req_next;
    fab_pkg::fab_ctl_t ctl_reg, ctl_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [18:0] addr_reg, addr_next;
    logic [15:0] dq_o_reg, dq_o_next;
    logic [15:0] dq_oe_n_reg, dq_oe_n_next;
    logic byte_n_reg, byte_n_next;
    logic ready_reg, ready_next;
    logic rsp_valid_reg, rsp_valid_next;
    logic [15:0] rsp_data_reg, rsp_data_next;
    logic is_write;
    logic is_prot;

    //--------------------------------------------------------------
    // request decode
    //--------------------------------------------------------------
    assign is_prot = (req_reg.op == `FAB_OP_PROTECT) || (req_reg.op == `FAB_OP_UNPROTECT);
    assign is_write = (req_reg.op == `FAB_OP_WRITE) || is_prot;

    //--------------------------------------------------------------
    // sequencer
    //--------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        req_next = req_reg;
        ctl_next = ctl_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        dq_o_next = dq_o_reg;
        dq_oe_n_next = dq_oe_n_reg;
        byte_n_next = byte_n_reg;
        ready_next = ready_reg;
        rsp_valid_next = 1'b0;
        rsp_data_next = rsp_data_reg;
        case (state_reg)
            fab_pkg::FAB_IDLE: begin
                if (REQ_VALID && ready_reg) begin
                    req_next = REQ;
                    ready_next = 1'b0;
                    cnt_next = 8'h00;
                    byte_n_next = REQ.word_mode;
                    addr_next = REQ.word_mode ? REQ.addr[18:0] : REQ.addr[19:1];
                    dq_oe_n_next = 16'hFFFF;
                    if (REQ.op == `FAB_OP_RESET) begin
                        ctl_next.rst_n = 1'b0;
                        state_next = fab_pkg::FAB_RESET;
                    end else begin
                        if (!REQ.word_mode) begin
                            // top pin carries address bit -1
                            dq_o_next = {REQ.addr[0], 15'h0000};
                            dq_oe_n_next = 16'h7FFF;
                        end
                        if (REQ.op == `FAB_OP_PROTECT || REQ.op == `FAB_OP_UNPROTECT) begin
                            addr_next[`FAB_PROT_A1_BIT] = 1'b1;
                            addr_next[`FAB_PROT_A0_BIT] = 1'b0;
                            addr_next[`FAB_PROT_A6_BIT] = (REQ.op == `FAB_OP_UNPROTECT);
                            ctl_next.hv_en = 1'b1;
                        end
                        ctl_next.ce_n = 1'b0;
                        state_next = fab_pkg::FAB_SETUP;
                    end
                end
            end
            fab_pkg::FAB_SETUP: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg + 8'h01 >= SU_CYC) begin
                    cnt_next = 8'h00;
                    if (is_write) begin
                        // write levels, address taken at this edge
                        ctl_next.oe_n = 1'b1;
                        ctl_next.we_n = 1'b0;
                        if (req_reg.word_mode) begin
                            dq_o_next = req_reg.wdata;
                            dq_oe_n_next = 16'h0000;
                        end else begin
                            dq_o_next = {dq_o_reg[15], 7'h00, req_reg.wdata[7:0]};
                            dq_oe_n_next = 16'h7F00;
                        end
                    end else begin
                        ctl_next.we_n = 1'b1;
                        ctl_next.oe_n = 1'b0;
                    end
                    state_next = fab_pkg::FAB_STROBE;
                end
            end
            fab_pkg::FAB_STROBE: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg + 8'h01 >= (is_write ? WP_CYC : ACC_CYC)) begin
                    cnt_next = 8'h00;
                    if (is_write) begin
                        // data latched on rising write enable
                        ctl_next.we_n = 1'b1;
                    end else begin
                        rsp_data_next = req_reg.word_mode ? DQ_I : {8'h00, DQ_I[7:0]};
                        rsp_valid_next = 1'b1;
                        ctl_next.oe_n = 1'b1;
                    end
                    state_next = fab_pkg::FAB_HOLD;
                end
            end
            fab_pkg::FAB_HOLD: begin
                ctl_next.ce_n = 1'b1;
                ctl_next.hv_en = 1'b0;
                dq_oe_n_next = 16'hFFFF;
                if (is_write) begin
                    rsp_valid_next = 1'b1;
                    rsp_data_next = 16'h0000;
                end
                ready_next = 1'b1;
                state_next = fab_pkg::FAB_IDLE;
            end
            fab_pkg::FAB_RESET: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg + 8'h01 >= RP_CYC) begin
                    cnt_next = 8'h00;
                    ctl_next.rst_n = 1'b1;
                    state_next = fab_pkg::FAB_RECOVER;
                end
            end
            fab_pkg::FAB_RECOVER: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg + 8'h01 >= RH_CYC && READY_BUSY_OUT) begin
                    cnt_next = 8'h00;
                    rsp_valid_next = 1'b1;
                    rsp_data_next = 16'h0000;
                    ready_next = 1'b1;
                    state_next = fab_pkg::FAB_IDLE;
                end
            end
            default: begin
                state_next = fab_pkg::FAB_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_reg <= fab_pkg::FAB_IDLE;
            req_reg <= '0;
            ctl_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1, hv_en: 1'b0};
            cnt_reg <= 8'h00;
            addr_reg <= 19'h00000;
            dq_o_reg <= 16'h0000;
            dq_oe_n_reg <= 16'hFFFF;
            byte_n_reg <= 1'b1;
            ready_reg <= 1'b1;
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            req_reg <= req_next;
            ctl_reg <= ctl_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            dq_o_reg <= dq_o_next;
            dq_oe_n_reg <= dq_oe_n_next;
            byte_n_reg <= byte_n_next;
            ready_reg <= ready_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_data_reg <= rsp_data_next;
        end
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    assign REQ_READY = ready_reg;
    assign RSP_VALID = rsp_valid_reg;
    assign RSP_DATA = rsp_data_reg;
    assign ADDR = addr_reg;
    assign CE_N = ctl_reg.ce_n;
    assign OE_N = ctl_reg.oe_n;
    assign WE_N = ctl_reg.we_n;
    assign RESET_N = ctl_reg.rst_n;
    assign HIGH_VOLTAGE_LEVEL = ctl_reg.hv_en;
    assign BYTE_N = byte_n_reg;
    assign DQ_O = dq_o_reg;
    assign DQ_OE_N = dq_oe_n_reg;
endmodule // fab_host
`default_nettype wire

// ---- tb/fab_host_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module fab_host_props (
    // clock, reset, request
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic REQ_VALID,
    input wire fab_pkg::fab_req_t REQ,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    // flash pins
    input wire logic [18:0] ADDR,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic WE_N,
    input wire logic RESET_N,
    input wire logic HIGH_VOLTAGE_LEVEL,
    input wire logic BYTE_N,
    input wire logic [15:0] DQ_O,
    input wire logic [15:0] DQ_OE_N
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    read_levels_a: assert property (!OE_N |-> !CE_N && WE_N && RESET_N)
        else $error("read strobe with wrong control levels");
    write_levels_a: assert property (!WE_N |-> !CE_N && OE_N)
        else $error("write strobe with wrong control levels");
    word_drive_a: assert property (!WE_N && BYTE_N |-> DQ_OE_N == 16'h0000)
        else $error("word write not driving all pins");
    byte_pins_a: assert property (!CE_N && !BYTE_N |-> DQ_OE_N[15:8] == 8'h7F)
        else $error("byte mode upper pin use wrong");
    read_release_a: assert property (!OE_N |-> DQ_OE_N[14:0] == 15'h7FFF)
        else $error("host drives data during read");
    prot_addr_a: assert property (HIGH_VOLTAGE_LEVEL && !WE_N |-> ADDR[1:0] == 2'h2)
        else $error("protect address bits wrong");
    wr_stable_a: assert property (!WE_N && $past(!WE_N) |-> $stable(ADDR) && $stable(DQ_O))
        else $error("address or data moved in write pulse");
    rst_pulse_a: assert property ($fell(RESET_N) |-> !RESET_N [*8])
        else $error("flash reset pulse too short");
    read_answer_a: assert property (REQ_VALID && REQ_READY && REQ.op == 3'h0 |-> ##[25:28] RSP_VALID)
        else $error("read answer late");
endmodule // fab_host_props
`default_nettype wire

// ---- tb/fab_flash_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fab_flash_model #(parameter int ACC_NS = 100) (
    // pins from host
    input wire logic mclk,
    input wire logic [18:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rst_n,
    input wire logic hv,
    input wire logic byte_n,
    input wire logic [15:0] dq_o,
    // pins to host, observation
    output logic [15:0] dq_i,
    output logic rb,
    output logic [36:0] lat,
    output int n_rst
);
    logic en, en_d;
    logic [15:0] w;
    logic [19:0] la;
    logic [15:0] junk = 16'h1234;
    initial begin
        rb = 1'b1;
        n_rst = 0;
        lat = '0;
    end
    always @(posedge mclk) junk <= {junk[14:0], ~junk[15]} ^ 16'h0101;
    assign en = !ce_n && !oe_n && rst_n === 1'b1;
    assign #(ACC_NS) en_d = en;
    assign w = addr[15:0] ^ 16'h5A3C;
    assign dq_i = !(en && en_d) ? junk : byte_n ? w : {junk[15:8], dq_o[15] ? w[15:8] : w[7:0]};
    // address on fall, data on rise
    always @(negedge we_n) if (!ce_n && rst_n) la = {addr, dq_o[15]};
    always @(posedge we_n) if (!ce_n && rst_n)
        lat = {hv, byte_n ? {1'b0, la[19:1]} : la, byte_n ? dq_o : {8'h00, dq_o[7:0]}};
    always @(negedge rst_n) n_rst++;
    always @(posedge rst_n) begin
        rb = 1'b0;
        // busy ends off a clock edge, no sampling race
        #151 rb = 1'b1;
    end
endmodule // fab_flash_model
`default_nettype wire

// ---- tb/flash_async_bus_decode_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module flash_async_bus_decode_tb;
    logic mclk = 0, sys_rst = 1, req_valid = 0, req_ready, rsp_valid, wm;
    logic ce_n, oe_n, we_n, rst_n, hv, byte_n, rb;
    logic [15:0] rsp_data, dq_o, dq_oe_n, dq_i, d;
    logic [18:0] addr;
    logic [19:0] a;
    logic [2:0] op;
    logic [36:0] lat;
    fab_pkg::fab_req_t req_s = '0;
    int n_rst, n_fail = 0, comparisons = 0, cycles = 0, k, nr;
    fab_host fab_host_i (.MCLK(mclk), .SYS_RST(sys_rst), .REQ_VALID(req_valid), .REQ(req_s),
        .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .ADDR(addr),
        .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .RESET_N(rst_n), .HIGH_VOLTAGE_LEVEL(hv),
        .BYTE_N(byte_n), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n), .READY_BUSY_OUT(rb));
    fab_flash_model fab_flash_model_i (.mclk(mclk), .addr(addr), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .rst_n(rst_n), .hv(hv), .byte_n(byte_n), .dq_o(dq_o), .dq_i(dq_i),
        .rb(rb), .lat(lat), .n_rst(n_rst));
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) if (++cycles == 5000) begin
        n_fail++;
        give_verdict();
    end
    task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_latch(input logic [36:0] got, input logic [36:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_event(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] exp_rd(input logic m, input logic [19:0] x);
        logic [15:0] v;
        v = (m ? x[15:0] : x[16:1]) ^ 16'h5A3C;
        return m ? v : {8'h00, x[0] ? v[15:8] : v[7:0]};
    endfunction
    function automatic logic [36:0] exp_lat(input logic [2:0] o, input logic m,
        input logic [19:0] x, input logic [15:0] y);
        logic [19:0] v;
        int p;
        v = m ? {1'b0, x[18:0]} : x;
        // byte mode puts the low address bit below the pin address
        p = m ? 0 : 1;
        if (o >= 3'h2) begin
            v[p + 6] = (o == 3'h3);
            v[p + 1] = 1'b1;
            v[p] = 1'b0;
        end
        return {o >= 3'h2, v, m ? y : {8'h00, y[7:0]}};
    endfunction
    task automatic do_req(input logic [2:0] o, input logic m, input logic [19:0] x,
        input logic [15:0] y);
        req_valid = 1'b1;
        req_s = '{op: o, word_mode: m, addr: x, wdata: y};
        do @(posedge mclk); while (req_ready !== 1'b1);
        #1 req_valid = 1'b0;
        for (k = 0; k < 400 && rsp_valid !== 1'b1; k++) begin
            @(posedge mclk);
            #1;
        end
        cmp_event(rsp_valid, 1'b1);
    endtask
    task give_verdict;
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        void'($urandom(80126));
        repeat (8) @(posedge mclk);
        #1 sys_rst = 1'b0;
        do_req(3'h0, 1'b1, 20'h00123, 16'h0000);
        cmp_data(rsp_data, exp_rd(1'b1, 20'h00123));
        for (int i = 0; i < 24; i++) begin
            op = (i < 4) ? 3'h0 : 3'($urandom % 2);
            wm = (i < 4) ? i[1] : 1'($urandom);
            a = (i < 4) ? {20{i[0]}} : 20'($urandom);
            d = 16'($urandom);
            if (wm) a[19] = 1'b0;
            do_req(op, wm, a, d);
            if (op == 3'h0) cmp_data(rsp_data, exp_rd(wm, a));
            else cmp_latch(lat, exp_lat(op, wm, a, d));
        end
        // protect and unprotect in both widths
        for (int i = 0; i < 4; i++) begin
            op = 3'h2 + 3'(i % 2);
            wm = i[1];
            a = 20'($urandom);
            if (wm) a[19] = 1'b0;
            do_req(op, wm, a, 16'hC3A5);
            cmp_latch(lat, exp_lat(op, wm, a, 16'hC3A5));
        end
        nr = n_rst;
        do_req(3'h4, 1'b1, 20'h00000, 16'h0000);
        cmp_event(n_rst, nr + 1);
        cmp_event(rb, 1'b1);
        do_req(3'h0, 1'b0, 20'hFFFFF, 16'h0000);
        cmp_data(rsp_data, exp_rd(1'b0, 20'hFFFFF));
        give_verdict();
    end
endmodule // flash_async_bus_decode_tb
bind fab_host fab_host_props fab_host_props_i (.MCLK(MCLK), .SYS_RST(SYS_RST),
    .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID),
    .ADDR(ADDR), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .RESET_N(RESET_N),
    .HIGH_VOLTAGE_LEVEL(HIGH_VOLTAGE_LEVEL), .BYTE_N(BYTE_N), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N));
`default_nettype wire
